// ---- src/oac_top.sv ----
`timescale 1ns/1ps
module oac_top
    import oac_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic timer_compare_channel_six,
    output logic amp_enable,
    output logic ext_feedback_mode,
    output logic follower_mode,
    output logic pga_enable,
    output logic [4:0] gain_tap,
    output logic [2:0] noninv_input_sel,
    output logic [1:0] inv_input_sel,
    output logic inv_input_connect,
    output logic [4:0] adc_channel
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_sync_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    // one wait cycle per access: the answer leaves a register
    logic ack_ff;
    logic hit_ctrl;
    logic hit_lock;
    logic full_word;
    logic req;
    assign req = (avs_read || avs_write) && !ack_ff;
    assign hit_ctrl = avs_address == OFS_CTRL;
    assign hit_lock = avs_address == OFS_LOCK;
    // registers take whole words only; partial writes are dropped
    assign full_word = avs_byteenable == 4'hF;

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !req;
        end
    end

    oac_cfg_if cfg ();

    oac_regs u_regs (
        .clk(clk),
        .rst_n(rst_sync_ff),
        .wr_ctrl(req && avs_write && hit_ctrl && full_word),
        .wr_lock(req && avs_write && hit_lock && full_word),
        .wdata(avs_writedata),
        .cfg(cfg.regs)
    );

    logic [31:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (hit_ctrl) begin
            nxt_rdata = cfg.ctrl;
        end else if (hit_lock) begin
            nxt_rdata[POS_LOCK] = cfg.lock;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            avs_readdata <= 32'h0000_0000;
        end else if (req && avs_read) begin
            avs_readdata <= nxt_rdata;
        end
    end

    // ----------------------------------------------------------------
    // input switching
    // ----------------------------------------------------------------
    // compare arrives synchronous; one register keeps the mux glitch-free
    logic cmp_ff;
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            cmp_ff <= 1'b0;
        end else begin
            cmp_ff <= timer_compare_channel_six;
        end
    end

    logic [31:0] c;
    logic use_sec;
    oac_mode_t mode;
    assign c = cfg.ctrl;
    assign mode = oac_mode_t'(c[POS_MODE +: 2]);
    assign use_sec = c[POS_TIMER_EN] && cmp_ff;

    // ----------------------------------------------------------------
    // analog control levels
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            noninv_input_sel <= 3'h0;
            inv_input_sel <= 2'h0;
        end else if (use_sec) begin
            noninv_input_sel <= c[POS_NONINV_SEC +: 3];
            inv_input_sel <= c[POS_INV_SEC +: 2];
        end else begin
            noninv_input_sel <= c[POS_NONINV_PRI +: 3];
            inv_input_sel <= c[POS_INV_PRI +: 2];
        end
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            amp_enable <= 1'b0;
            ext_feedback_mode <= 1'b0;
            follower_mode <= 1'b0;
            pga_enable <= 1'b0;
            inv_input_connect <= 1'b0;
            gain_tap <= 5'h01;
            adc_channel <= ADC_CHANNEL_SIX;
        end else begin
            amp_enable <= c[POS_EN];
            ext_feedback_mode <= mode == OAC_MODE_EXT0 || mode == OAC_MODE_EXT1;
            follower_mode <= mode == OAC_MODE_FOLLOW;
            pga_enable <= mode == OAC_MODE_PGA;
            // pin switch only in external mode; follower ties it inside
            inv_input_connect <= mode == OAC_MODE_EXT0 || mode == OAC_MODE_EXT1;
            gain_tap <= oac_gain_tap(c[POS_GAIN +: 3]);
            adc_channel <= ADC_CHANNEL_SIX;
        end
    end
endmodule // oac_top

// ---- src/oac_pkg.sv ----
// Operation
// - codes 00/01 select standalone external feedback
// - code 11 selects follower, inverting input internal
// - code 10 enables internal resistive gain network
// - five internal gains, two to thirty-two
// - gain codes 0..4 map 2..32, others 2
// - lock set ignores configuration writes
// - lock clears only on chip reset
// - one lock write accepted per reset
// - switching enabled and compare high selects secondary
// - otherwise primary selections drive switches
// - timer enable bit (13) allows automatic switching
// - amplifier output feeds converter channel six
package oac_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LOCK = 8'h10;
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic RST_LOCK = 1'b0;
    // bits 31:20, 16, 12 and 8 are reserved and always read back zero
    localparam logic [31:0] CTRL_WMASK = 32'h000E_EEFF;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int POS_EN = 0;
    localparam int POS_MODE = 1;
    localparam int POS_GAIN = 3;
    localparam int POS_INV_PRI = 6;
    localparam int POS_NONINV_PRI = 9;
    localparam int POS_TIMER_EN = 13;
    localparam int POS_INV_SEC = 14;
    localparam int POS_NONINV_SEC = 17;
    localparam int POS_LOCK = 0;
    localparam logic [4:0] ADC_CHANNEL_SIX = 5'h06;

    typedef enum logic [1:0] {
        OAC_MODE_EXT0 = 2'b00,
        OAC_MODE_EXT1 = 2'b01,
        OAC_MODE_PGA = 2'b10,
        OAC_MODE_FOLLOW = 2'b11
    } oac_mode_t;

    // one-hot gain tap: bit0 = x2 ... bit4 = x32
    function automatic logic [4:0] oac_gain_tap(input logic [2:0] code);
        logic [4:0] tap;
        tap = 5'h01;
        unique case (code)
            3'h0: tap = 5'h01;
            3'h1: tap = 5'h02;
            3'h2: tap = 5'h04;
            3'h3: tap = 5'h08;
            3'h4: tap = 5'h10;
            default: tap = 5'h01;
        endcase
        return tap;
    endfunction
endpackage

// ---- src/oac_cfg_if.sv ----
`timescale 1ns/1ps
interface oac_cfg_if;
    logic [31:0] ctrl;
    logic lock;
    modport regs (output ctrl, output lock);
    modport core (input ctrl, input lock);
endinterface

// ---- src/oac_regs.sv ----
`timescale 1ns/1ps
module oac_regs
    import oac_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_ctrl,
    input wire logic wr_lock,
    input wire logic [31:0] wdata,
    oac_cfg_if.regs cfg
);
    logic [31:0] ctrl_ff;
    logic lock_ff;
    logic lock_used_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= RST_CTRL;
        end else if (wr_ctrl && !lock_ff) begin
            ctrl_ff <= wdata & CTRL_WMASK;
        end
    end

    // lock has no clear path other than reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_ff <= RST_LOCK;
            lock_used_ff <= 1'b0;
        end else if (wr_lock && !lock_used_ff) begin
            lock_ff <= wdata[POS_LOCK];
            lock_used_ff <= 1'b1;
        end
    end

    assign cfg.ctrl = ctrl_ff;
    assign cfg.lock = lock_ff;
endmodule // oac_regs

// ---- bench/oac_chk.sv ----
`timescale 1ns/1ps
module oac_chk (
    input logic clk,
    input logic rst_n,
    input logic [7:0] avs_address,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0] avs_byteenable,
    input logic avs_waitrequest,
    input logic timer_compare_channel_six,
    input logic ext_feedback_mode,
    input logic follower_mode,
    input logic pga_enable,
    input logic [4:0] gain_tap,
    input logic [2:0] noninv_input_sel,
    input logic [1:0] inv_input_sel,
    input logic [4:0] adc_channel
);
    logic [31:0] cr_ff;
    logic [2:0] gc;
    logic lk_ff, used_ff, wr, cw, tc;
    assign wr = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
    assign cw = wr && avs_address == 8'h00 && !lk_ff;
    assign tc = timer_compare_channel_six && cr_ff[13];
    assign gc = cr_ff[5:3];
    // shadow lands on the same edge as the outputs, so it can stand in for them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cr_ff <= 32'h0;
            lk_ff <= 1'b0;
            used_ff <= 1'b0;
        end else begin
            cr_ff <= cw ? avs_writedata & 32'h000EEEFF : cr_ff;
            lk_ff <= wr && avs_address == 8'h10 && !used_ff ? avs_writedata[0] : lk_ff;
            used_ff <= used_ff || wr && avs_address == 8'h10;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    mode_ext_a: assert property (cw && !avs_writedata[2] |=> ext_feedback_mode
        && !pga_enable) else $error("ext mode");
    mode_fol_a: assert property (cw && avs_writedata[2:1] == 2'h3 |=> follower_mode
        && !ext_feedback_mode) else $error("follower");
    mode_pga_a: assert property (cw && avs_writedata[2:1] == 2'h2 |=> pga_enable
        && !follower_mode) else $error("pga");
    gain_tap_a: assert property (cw |=> gain_tap == (gc > 3'h4 ? 5'h01 : 5'h01 << gc))
        else $error("gain");
    lock_hold_a: assert property (lk_ff |=> $stable({ext_feedback_mode, follower_mode,
        pga_enable, gain_tap})) else $error("locked");
    sel_sec_a: assert property ((tc && $stable(cr_ff)) [*3] |-> noninv_input_sel
        == cr_ff[19:17] && inv_input_sel == cr_ff[15:14]) else $error("secondary");
    sel_pri_a: assert property ((!tc && $stable(cr_ff)) [*3] |-> noninv_input_sel
        == cr_ff[11:9] && inv_input_sel == cr_ff[7:6]) else $error("primary");
    adc_six_a: assert property (adc_channel == 5'h06) else $error("adc");
endmodule // oac_chk
bind oac_top oac_chk u_oac_chk (.*);

// ---- bench/oac_amp.sv ----
`timescale 1ns/1ps
module oac_amp (
    input logic pga_enable,
    input logic [4:0] gain_tap,
    output int gain
);
    // 0 means the internal network is off: the external network or follower mode sets the gain
    always_comb begin
        gain = 0;
        for (int k = 0; k < 5; k++) begin
            if (pga_enable && gain_tap[k]) gain = 2 << k;
        end
    end
endmodule // oac_amp

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic timer_compare_channel_six = 1'b0, avs_waitrequest, amp_enable;
    logic ext_feedback_mode, follower_mode, pga_enable, inv_input_connect;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [3:0] avs_byteenable = 4'hF;
    logic [4:0] gain_tap, adc_channel;
    logic [2:0] noninv_input_sel;
    logic [1:0] inv_input_sel;
    int gain, n_errors = 0, checks_done = 0;
    always #25 clk = ~clk;
    oac_top u_oac_top (.*);
    oac_amp u_oac_amp (.*);
    task automatic results();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value at %0t: %h not %h", $time, s, e);
        end
    endtask
    // idle edge after release keeps back-to-back calls from colliding
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        logic seen = 1'b0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            n++;
            seen = avs_waitrequest === 1'b0;
        end while (!seen && n < 9);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
        if (!seen) begin
            n_errors++;
            results();
        end
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic t_modes();
        for (int i = 0; i < 8; i++) begin
            acc(1, 8'h00, {26'h0, i[2:0], i[1:0], 1'b1});
            chk({ext_feedback_mode, follower_mode, pga_enable},
                i[1] ? (i[0] ? 3'h2 : 3'h1) : 3'h4);
            chk(gain_tap, i > 4 ? 5'h01 : 5'h01 << i);
            chk(gain, i[1:0] == 2'h2 ? (i > 4 ? 2 : 2 << i) : 0);
            chk(inv_input_connect, i[1] ? 32'h0 : 32'h1);
            chk(amp_enable, 32'h1);
        end
        chk(adc_channel, 5'h06);
        $display("mode test done");
    endtask
    task automatic t_switch();
        acc(1, 8'h00, 32'h2000);
        acc(1, 8'h00, 32'h66A80);
        acc(1, 8'h00, 32'h66A81);
        timer_compare_channel_six <= 1'b1;
        repeat (2) @(posedge clk);
        chk({noninv_input_sel, inv_input_sel}, 5'h16);
        @(posedge clk);
        chk({noninv_input_sel, inv_input_sel}, 5'h0D);
        timer_compare_channel_six <= 1'b0;
        repeat (3) @(posedge clk);
        chk({noninv_input_sel, inv_input_sel}, 5'h16);
        timer_compare_channel_six <= 1'b1;
        acc(1, 8'h00, 32'h64A81);
        @(posedge clk);
        chk({noninv_input_sel, inv_input_sel}, 5'h16);
        $display("switch test done");
    endtask
    task automatic t_lock();
        acc(1, 8'h00, 32'hFFF1_1115);
        acc(0, 8'h00, 32'h0);
        chk(q, 32'h15);
        acc(1, 8'h00, 32'h15);
        acc(1, 8'h10, 32'h1);
        acc(1, 8'h00, 32'h7);
        acc(0, 8'h00, 32'h0);
        chk(q, 32'h15);
        acc(1, 8'h10, 32'h0);
        acc(0, 8'h10, 32'h0);
        chk(q, 32'h1);
        do_reset();
        acc(0, 8'h00, 32'h0);
        chk(q, 32'h0);
        chk(amp_enable, 32'h0);
        acc(1, 8'h10, 32'h0);
        acc(1, 8'h10, 32'h1);
        acc(0, 8'h10, 32'h0);
        chk(q, 32'h0);
        acc(1, 8'h20, 32'h5);
        acc(0, 8'h20, 32'h0);
        chk(q, 32'h0);
        $display("lock test done");
    endtask
    initial begin
        do_reset();
        t_modes();
        t_switch();
        t_lock();
        results();
    end
endmodule // testbench
